// *** design/dbg_port_decode.sv ***
// Purpose: Register decode of a debug port reached by scan chain or serial wire.
// Assumes: Link fields come from another clock domain; posted_read_value is on core_clk.
// Notes: One access is taken per rising link_clk edge seen with link_req high.
`default_nettype none

module dbg_port_decode
   import dbg_port_pkg::*;
#(
   parameter logic [DATA_W-1:0] IDENT_VALUE = 32'h1000_0001 // Arbitrary value
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic link_clk,
   input wire logic link_req,
   input wire logic link_serial,
   input wire logic [1:0] link_instr,
   input wire logic [1:0] link_addr,
   input wire logic link_rnw,
   input wire logic [DATA_W-1:0] link_wdata,
   input wire logic [DATA_W-1:0] posted_read_value,
   output logic resp_valid,
   output logic resp_ok,
   output logic [DATA_W-1:0] resp_rdata,
   output logic cancel_strobe,
   output logic [DATA_W-1:0] cancel_value,
   output logic [DATA_W-1:0] ctrl_status,
   output logic [DATA_W-1:0] wire_config,
   output logic [DATA_W-1:0] bank_choice,
   output logic control_window_selector
);

   if (CTRL_SEL_BIT >= DATA_W) begin : g_check
      $error("selector bit lies outside the bank choice register");
   end

   localparam int FIELD_W = DATA_W + 7;

   logic link_rise;
   logic [FIELD_W-1:0] fields_q;
   logic s_req, s_serial, s_rnw;
   logic [1:0] s_instr_bits, s_addr;
   logic [DATA_W-1:0] s_wdata;
   instr_e s_instr;
   logic [3:0] full_addr;
   logic fire;
   logic selector;
   target_e tgt;

   link_sampler #(
      .WIDTH(FIELD_W)
   ) u_sampler (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .link_clk(link_clk),
      .fields({link_req, link_serial, link_instr, link_addr, link_rnw, link_wdata}),
      .link_rise(link_rise),
      .fields_q(fields_q)
   );

   assign {s_req, s_serial, s_instr_bits, s_addr, s_rnw, s_wdata} = fields_q;
   assign s_instr = instr_e'(s_instr_bits);
   assign full_addr = {s_addr, ADDR_LOW_BITS};
   assign fire = link_rise & s_req & ce;

   logic resp_valid_reg, resp_valid_next;
   logic resp_ok_reg, resp_ok_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic cancel_strobe_reg, cancel_strobe_next;
   logic [DATA_W-1:0] cancel_value_reg, cancel_value_next;
   logic [DATA_W-1:0] ctrl_status_reg, ctrl_status_next;
   logic [DATA_W-1:0] wire_config_reg, wire_config_next;
   logic [DATA_W-1:0] bank_choice_reg, bank_choice_next;
   logic [DATA_W-1:0] last_read_reg, last_read_next;

   assign selector = bank_choice_reg[CTRL_SEL_BIT];

   // Address decode: pick the one register this access reaches
   always_comb begin
      tgt = tgt_none;
      if (s_serial) begin
         // Read and write see different registers at most slots
         case (full_addr)
            OFS_ZERO: tgt = s_rnw ? tgt_ident : tgt_cancel;
            OFS_CTRL: tgt = selector ? tgt_wire : tgt_ctrl;
            OFS_BANK: tgt = s_rnw ? tgt_resend : tgt_bank;
            default: tgt = s_rnw ? tgt_posted : tgt_zero;
         endcase
      end else begin
         unique case (s_instr)
            identity_instr: tgt = tgt_ident;
            port_access_instr: begin
               // Slot zero is reserved; a well-behaved debugger never goes there
               case (full_addr)
                  OFS_ZERO: tgt = tgt_zero;
                  OFS_CTRL: tgt = tgt_ctrl;
                  OFS_BANK: tgt = tgt_bank;
                  default: tgt = tgt_zero;
               endcase
            end
            cancel_instr: begin
               // Other cancel accesses are undefined for the debugger; we make them harmless
               tgt = (full_addr == OFS_ZERO && !s_rnw) ? tgt_cancel : tgt_zero;
            end
            instr_other: tgt = tgt_none;
         endcase
      end
   end

   always_comb begin
      resp_valid_next = 1'b0;
      resp_ok_next = resp_ok_reg;
      rdata_next = rdata_reg;
      cancel_strobe_next = 1'b0;
      cancel_value_next = cancel_value_reg;
      ctrl_status_next = ctrl_status_reg;
      wire_config_next = wire_config_reg;
      bank_choice_next = bank_choice_reg;
      last_read_next = last_read_reg;
      if (fire) begin
         resp_valid_next = 1'b1;
         resp_ok_next = (tgt != tgt_none);
         rdata_next = READ_ZERO;
         unique case (tgt)
            tgt_ident: rdata_next = IDENT_VALUE;
            tgt_ctrl: begin
               if (s_rnw) begin
                  rdata_next = ctrl_status_reg;
               end else begin
                  ctrl_status_next = s_wdata;
               end
            end
            tgt_wire: begin
               if (s_rnw) begin
                  rdata_next = wire_config_reg;
               end else begin
                  wire_config_next = s_wdata;
               end
            end
            tgt_bank: begin
               if (s_rnw) begin
                  rdata_next = bank_choice_reg;
               end else begin
                  bank_choice_next = s_wdata;
               end
            end
            tgt_resend: rdata_next = last_read_reg;
            tgt_posted: rdata_next = posted_read_value;
            tgt_cancel: begin
               // Never stalled, so the debugger's first try always lands
               cancel_strobe_next = 1'b1;
               cancel_value_next = s_wdata;
            end
            tgt_zero, tgt_none: begin
               // Nothing stored; only the response is signalled
            end
         endcase
         // A resend must return the value sent before it, not itself
         if (s_serial && s_rnw && tgt != tgt_resend) begin
            last_read_next = rdata_next;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         resp_valid_reg <= 1'b0;
         resp_ok_reg <= 1'b0;
         rdata_reg <= READ_ZERO;
         cancel_strobe_reg <= 1'b0;
         cancel_value_reg <= READ_ZERO;
         ctrl_status_reg <= CTRL_STATUS_RST;
         wire_config_reg <= WIRE_CONFIG_RST;
         bank_choice_reg <= BANK_CHOICE_RST;
         last_read_reg <= LAST_READ_RST;
      end else if (ce) begin
         resp_valid_reg <= resp_valid_next;
         resp_ok_reg <= resp_ok_next;
         rdata_reg <= rdata_next;
         cancel_strobe_reg <= cancel_strobe_next;
         cancel_value_reg <= cancel_value_next;
         ctrl_status_reg <= ctrl_status_next;
         wire_config_reg <= wire_config_next;
         bank_choice_reg <= bank_choice_next;
         last_read_reg <= last_read_next;
      end
   end

   assign resp_valid = resp_valid_reg;
   assign resp_ok = resp_ok_reg;
   assign resp_rdata = rdata_reg;
   assign cancel_strobe = cancel_strobe_reg;
   assign cancel_value = cancel_value_reg;
   assign ctrl_status = ctrl_status_reg;
   assign wire_config = wire_config_reg;
   assign bank_choice = bank_choice_reg;
   assign control_window_selector = bank_choice_reg[CTRL_SEL_BIT];

   // Checks on the decode

   sequence s_scan_fire;
      fire && !s_serial;
   endsequence

   sequence s_serial_fire;
      fire && s_serial;
   endsequence

   property p_other_instr;
      @(posedge core_clk) disable iff (!nrst)
      s_scan_fire and (s_instr == instr_other) |=> resp_valid && !resp_ok && !cancel_strobe;
   endproperty
   a_other_instr: assert property (p_other_instr) else $error("non-port instruction reached a register");

   property p_ident_scan;
      @(posedge core_clk) disable iff (!nrst)
      s_scan_fire and (s_instr == identity_instr) |=> resp_ok && resp_rdata == IDENT_VALUE;
   endproperty
   a_ident_scan: assert property (p_ident_scan) else $error("identity chain did not return identity");

   property p_reserved_zero;
      @(posedge core_clk) disable iff (!nrst)
      s_scan_fire and (s_instr == port_access_instr && s_addr == 2'h0 && !s_rnw)
         |=> $stable(ctrl_status) && $stable(bank_choice) && !cancel_strobe;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved slot write had an effect");

   property p_bank_write_scan;
      logic [DATA_W-1:0] d;
      @(posedge core_clk) disable iff (!nrst)
      (s_scan_fire and (s_instr == port_access_instr && s_addr == 2'h2 && !s_rnw), d = s_wdata)
         |=> bank_choice == d;
   endproperty
   a_bank_write_scan: assert property (p_bank_write_scan) else $error("bank choice write lost");

   property p_posted_scan_zero;
      @(posedge core_clk) disable iff (!nrst)
      s_scan_fire and (s_instr == port_access_instr && s_addr == 2'h3) |=> resp_rdata == READ_ZERO;
   endproperty
   a_posted_scan_zero: assert property (p_posted_scan_zero) else $error("posted result not zero on scan");

   property p_cancel_scan;
      logic [DATA_W-1:0] d;
      @(posedge core_clk) disable iff (!nrst)
      (s_scan_fire and (s_instr == cancel_instr && s_addr == 2'h0 && !s_rnw), d = s_wdata)
         |=> cancel_strobe && cancel_value == d ##1 !cancel_strobe;
   endproperty
   a_cancel_scan: assert property (p_cancel_scan) else $error("cancel write not delivered once");

   property p_serial_ident;
      @(posedge core_clk) disable iff (!nrst)
      s_serial_fire and (s_addr == 2'h0 && s_rnw) |=> resp_ok && resp_rdata == IDENT_VALUE;
   endproperty
   a_serial_ident: assert property (p_serial_ident) else $error("serial read at zero not identity");

   property p_wire_window;
      logic [DATA_W-1:0] d;
      @(posedge core_clk) disable iff (!nrst)
      (s_serial_fire and (s_addr == 2'h1 && !s_rnw && selector), d = s_wdata)
         |=> wire_config == d && $stable(ctrl_status);
   endproperty
   a_wire_window: assert property (p_wire_window) else $error("selector did not steer to wire config");

   property p_resend;
      @(posedge core_clk) disable iff (!nrst)
      s_serial_fire and (s_addr == 2'h2 && s_rnw) |=> resp_rdata == $past(last_read_reg);
   endproperty
   a_resend: assert property (p_resend) else $error("repeat read returned a new value");

   property p_posted_serial;
      @(posedge core_clk) disable iff (!nrst)
      s_serial_fire and (s_addr == 2'h3 && s_rnw) |=> resp_rdata == $past(posted_read_value);
   endproperty
   a_posted_serial: assert property (p_posted_serial) else $error("posted result read wrong");

   property p_cancel_ok;
      @(posedge core_clk) disable iff (!nrst)
      cancel_strobe |-> resp_valid && resp_ok;
   endproperty
   a_cancel_ok: assert property (p_cancel_ok) else $error("cancel access not acknowledged");

endmodule

`default_nettype wire

// *** design/dbg_port_pkg.sv ***
// Purpose: Shared constants and types for the debug port register decode.
// Assumes: Four-bit register addresses built from a two-bit link address field.
// Notes: Reset values are all zero; the only register field decoded is the control window selector bit in bank choice.
`default_nettype none

package dbg_port_pkg;

   localparam int DATA_W = 32;

   // Low address bits are never transferred and always read as zero
   localparam logic [1:0] ADDR_LOW_BITS = 2'h0;

   // Byte offsets of the four register slots
   localparam logic [3:0] OFS_ZERO = 4'h0;
   localparam logic [3:0] OFS_CTRL = 4'h4;
   localparam logic [3:0] OFS_BANK = 4'h8;
   localparam logic [3:0] OFS_POSTED = 4'hC;

   // Position of the control window selector inside the bank choice register
   localparam int CTRL_SEL_BIT = 0;

   // Values after reset
   localparam logic [DATA_W-1:0] CTRL_STATUS_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] WIRE_CONFIG_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] BANK_CHOICE_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] LAST_READ_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

   // Scan-chain instruction as presented by the link
   typedef enum logic [1:0] {
      instr_other = 2'h0,
      identity_instr = 2'h1,
      port_access_instr = 2'h2,
      cancel_instr = 2'h3
   } instr_e;

   // Register reached by one access, one-hot
   typedef enum logic [8:0] {
      tgt_none = 9'h001,
      tgt_zero = 9'h002,
      tgt_ident = 9'h004,
      tgt_ctrl = 9'h008,
      tgt_wire = 9'h010,
      tgt_bank = 9'h020,
      tgt_resend = 9'h040,
      tgt_posted = 9'h080,
      tgt_cancel = 9'h100
   } target_e;

endpackage

`default_nettype wire

// *** design/link_sampler.sv ***
// Purpose: Brings a group of link-domain inputs and the link clock into core_clk.
// Assumes: Link fields are held stable across the whole high phase of link_clk.
// Notes: link_rise and fields_q are aligned; both come one cycle after the second stage.
`default_nettype none

module link_sampler #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic link_clk,
   input wire logic [WIDTH-1:0] fields,
   output logic link_rise,
   output logic [WIDTH-1:0] fields_q
);

   if (WIDTH < 1) begin : g_check
      $error("link_sampler needs WIDTH of at least 1");
   end

   logic [WIDTH:0] stage1_reg, stage2_reg, stage3_reg;
   logic [WIDTH:0] stage1_next, stage2_next, stage3_next;
   logic rise_reg, rise_next;

   // First stage feeds only the second stage
   always_comb begin
      stage1_next = {link_clk, fields};
      stage2_next = stage1_reg;
      stage3_next = stage2_reg;
      rise_next = stage2_reg[WIDTH] & ~stage3_reg[WIDTH];
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
         rise_reg <= 1'b0;
      end else if (ce) begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
         stage3_reg <= stage3_next;
         rise_reg <= rise_next;
      end
   end

   assign link_rise = rise_reg;
   assign fields_q = stage3_reg[WIDTH-1:0];

endmodule

`default_nettype wire

// *** tb/dbg_host_model.sv ***
// Purpose: Debugger-side model that drives the link pins of the debug port.
// Assumes: core_clk paces the link; one access spans 9 core cycles, link_clk high for 4.
// Notes: link_clk stands still low between accesses; idle fields show inverted data.
`default_nettype none

module dbg_host_model (
   input wire logic core_clk,
   output logic link_clk,
   output logic link_req,
   output logic link_serial,
   output logic [1:0] link_instr,
   output logic [1:0] link_addr,
   output logic link_rnw,
   output logic [31:0] link_wdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {link_clk, link_req, link_serial, link_instr, link_addr, link_rnw, link_wdata} = '0;
   end

   // Fields settle one cycle before the rising edge and hold through the high phase
   task automatic access(input logic ser, input logic [1:0] ins, input logic [3:0] byte_addr,
      input logic rnw, input logic [31:0] wd);
      @(posedge core_clk);
      {link_req, link_serial, link_instr, link_addr, link_rnw, link_wdata} <=
         {1'h1, ser, ins, byte_addr[3:2], rnw, wd};
      @(posedge core_clk);
      link_clk <= 1'h1;
      repeat (4) @(posedge core_clk);
      link_clk <= 1'h0;
      // Released fields must not keep the last value, else a stale sample could pass
      {link_req, link_serial, link_instr, link_addr, link_rnw, link_wdata} <=
         ~{1'h1, ser, ins, byte_addr[3:2], rnw, wd};
      repeat (3) @(posedge core_clk);
   endtask
   // Address zero under port access and cancel-chain read data are only used by deliberate tests

endmodule

`default_nettype wire

// *** tb/test_dbg_port_decode.sv ***
// Purpose: Self-checking bench for the debug port register decode.
// Assumes: Design answers one access per link_clk rise; ce stays high except in t_clock_enable, which holds it low for one access.
// Notes: Expected data comes from the bench's own constants, not the design.
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end

module test_dbg_port_decode;
   import dbg_port_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] IDENT = 32'h2468_ACE1; // Arbitrary value
   localparam logic [31:0] POSTED = 32'hC3C3_1234;
   int n_errors = 0;
   int checked = 0;
   logic core_clk = 1'h0;
   logic nrst = 1'h0;
   logic ce = 1'h1;
   logic [31:0] posted_read_value = POSTED;
   wire logic link_clk, link_req, link_serial, link_rnw;
   wire logic [1:0] link_instr, link_addr;
   wire logic [31:0] link_wdata;
   logic resp_valid, resp_ok, cancel_strobe, control_window_selector;
   logic [31:0] resp_rdata, cancel_value, ctrl_status, wire_config, bank_choice;

   always #20 core_clk = ~core_clk;

   dbg_host_model u_host (.core_clk(core_clk), .link_clk(link_clk), .link_req(link_req),
      .link_serial(link_serial), .link_instr(link_instr), .link_addr(link_addr),
      .link_rnw(link_rnw), .link_wdata(link_wdata));

   dbg_port_decode #(.IDENT_VALUE(IDENT)) u_dut (.core_clk(core_clk), .nrst(nrst), .ce(ce),
      .link_clk(link_clk), .link_req(link_req), .link_serial(link_serial),
      .link_instr(link_instr), .link_addr(link_addr), .link_rnw(link_rnw),
      .link_wdata(link_wdata), .posted_read_value(posted_read_value),
      .resp_valid(resp_valid), .resp_ok(resp_ok), .resp_rdata(resp_rdata),
      .cancel_strobe(cancel_strobe), .cancel_value(cancel_value), .ctrl_status(ctrl_status),
      .wire_config(wire_config), .bank_choice(bank_choice),
      .control_window_selector(control_window_selector));

   task automatic finish_test();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One link access; the answer pulse is judged in the cycle it stands
   task automatic xfer(input logic ser, input logic [1:0] ins, input logic [3:0] a, input logic rnw,
      input logic [31:0] wd, input logic ok, input logic [31:0] rd, input logic cs);
      int n;
      logic seen;
      seen = 1'h0;
      fork
         u_host.access(ser, ins, a, rnw, wd);
         for (n = 0; n < 20 && !seen; n++) begin
            @(posedge core_clk);
            #1;
            if (resp_valid === 1'h1) begin
               seen = 1'h1;
               `CHK(resp_ok, ok)
               `CHK(resp_rdata, rd)
               `CHK(cancel_strobe, cs)
            end
         end
      join
      if (!seen) begin
         n_errors++;
         finish_test();
      end
   endtask

   task automatic t_reset();
      `CHK(resp_valid, 1'h0)
      `CHK(ctrl_status, 32'h0)
      `CHK(bank_choice, 32'h0)
      `CHK(cancel_value, 32'h0)
      $display("test reset done");
   endtask

   task automatic t_scan_instr();
      xfer(1'h0, 2'h0, 4'h4, 1'h1, 32'h0, 1'h0, 32'h0, 1'h0);
      xfer(1'h0, 2'h0, 4'h4, 1'h0, 32'hFFFF_FFFF, 1'h0, 32'h0, 1'h0);
      `CHK(ctrl_status, 32'h0)
      xfer(1'h0, 2'h1, 4'hC, 1'h1, 32'h0, 1'h1, IDENT, 1'h0);
      $display("test scan_instr done");
   endtask

   task automatic t_scan_port();
      xfer(1'h0, 2'h2, 4'h4, 1'h0, 32'hA5A5_0101, 1'h1, 32'h0, 1'h0);
      `CHK(ctrl_status, 32'hA5A5_0101)
      xfer(1'h0, 2'h2, 4'h8, 1'h0, 32'h5A5A_0F0E, 1'h1, 32'h0, 1'h0);
      xfer(1'h0, 2'h2, 4'h4, 1'h1, 32'h0, 1'h1, 32'hA5A5_0101, 1'h0);
      xfer(1'h0, 2'h2, 4'h8, 1'h1, 32'h0, 1'h1, 32'h5A5A_0F0E, 1'h0);
      xfer(1'h0, 2'h2, 4'hC, 1'h1, 32'h0, 1'h1, 32'h0, 1'h0);
      xfer(1'h0, 2'h2, 4'hC, 1'h0, 32'h1111_2222, 1'h1, 32'h0, 1'h0);
      xfer(1'h0, 2'h2, 4'h0, 1'h1, 32'h0, 1'h1, 32'h0, 1'h0);
      xfer(1'h0, 2'h2, 4'h0, 1'h0, 32'h3333_4444, 1'h1, 32'h0, 1'h0);
      `CHK(ctrl_status, 32'hA5A5_0101)
      `CHK(bank_choice, 32'h5A5A_0F0E)
      `CHK(wire_config, 32'h0)
      `CHK(cancel_value, 32'h0)
      $display("test scan_port done");
   endtask

   task automatic t_scan_cancel();
      xfer(1'h0, 2'h3, 4'h0, 1'h0, 32'h0000_0001, 1'h1, 32'h0, 1'h1);
      `CHK(cancel_value, 32'h0000_0001)
      xfer(1'h0, 2'h3, 4'h4, 1'h0, 32'h7777_0000, 1'h1, 32'h0, 1'h0);
      `CHK(cancel_value, 32'h0000_0001)
      `CHK(ctrl_status, 32'hA5A5_0101)
      $display("test scan_cancel done");
   endtask

   task automatic t_serial();
      xfer(1'h1, 2'h0, 4'h0, 1'h1, 32'h0, 1'h1, IDENT, 1'h0);
      xfer(1'h1, 2'h0, 4'h0, 1'h0, 32'h0000_001E, 1'h1, 32'h0, 1'h1);
      `CHK(cancel_value, 32'h0000_001E)
      xfer(1'h1, 2'h0, 4'h4, 1'h0, 32'hD1D1_0000, 1'h1, 32'h0, 1'h0);
      `CHK(ctrl_status, 32'hD1D1_0000)
      `CHK(wire_config, 32'h0)
      xfer(1'h1, 2'h0, 4'h8, 1'h0, 32'h0000_0001, 1'h1, 32'h0, 1'h0);
      `CHK(control_window_selector, 1'h1)
      xfer(1'h1, 2'h0, 4'h4, 1'h0, 32'h0000_0D2D, 1'h1, 32'h0, 1'h0);
      `CHK(wire_config, 32'h0000_0D2D)
      `CHK(ctrl_status, 32'hD1D1_0000)
      xfer(1'h1, 2'h0, 4'h4, 1'h1, 32'h0, 1'h1, 32'h0000_0D2D, 1'h0);
      xfer(1'h1, 2'h0, 4'h0, 1'h0, 32'h0000_0004, 1'h1, 32'h0, 1'h1);
      xfer(1'h1, 2'h0, 4'hC, 1'h1, 32'h0, 1'h1, POSTED, 1'h0);
      xfer(1'h1, 2'h0, 4'h8, 1'h1, 32'h0, 1'h1, POSTED, 1'h0);
      xfer(1'h1, 2'h0, 4'hC, 1'h0, 32'hEEEE_EEEE, 1'h1, 32'h0, 1'h0);
      `CHK(bank_choice, 32'h0000_0001)
      `CHK(wire_config, 32'h0000_0D2D)
      xfer(1'h1, 2'h0, 4'h0, 1'h1, 32'h0, 1'h1, IDENT, 1'h0);
      $display("test serial done");
   endtask

   // A whole access with ce low must leave no trace, not even in the resend value
   task automatic t_clock_enable();
      int n;
      @(posedge core_clk);
      ce <= 1'h0;
      fork
         u_host.access(1'h1, 2'h0, 4'h8, 1'h0, 32'h0000_0000);
         for (n = 0; n < 12; n++) begin
            @(posedge core_clk);
            #1;
            `CHK(resp_valid, 1'h0)
         end
      join
      `CHK(bank_choice, 32'h0000_0001)
      @(posedge core_clk);
      ce <= 1'h1;
      xfer(1'h1, 2'h0, 4'h8, 1'h1, 32'h0, 1'h1, IDENT, 1'h0);
      $display("test clock_enable done");
   endtask

   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'h1;
      @(posedge core_clk);
      #1;
      t_reset();
      t_scan_instr();
      t_scan_port();
      t_scan_cancel();
      t_serial();
      t_clock_enable();
      finish_test();
   end

endmodule

`default_nettype wire
